// ===== src/uart_modem_status_special_function.v
// modem status and special function registers of one uart channel
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uart_msr_sfr_consts.vh"

// What this block does
// R1: cts change in either direction sets flag
// R2: dsr change in either direction sets flag
// R3: ri rising edge only sets flag
// R4: dcd change in either direction sets flag
// R5: read-only cts level bit, resets zero
// R6: read-only dsr level bit, resets zero
// R7: read-only ri level bit, resets zero
// R8: dcd level in status bit 7
// R9: special bit 0 forces transmitter on
// R10: special bit 1 enables dsr/dtr flow control
// R11: special bit 5 selects extended compatibility mode
// R12: special bit 6 picks error or rx count
// R13: special bit 7 picks tx count or sample clock
// R14: loopback routes general outputs to ri, dcd
// R15: status bits 0-3 flags, 4-7 levels
// R16: change in read cycle keeps flag set
module uart_modem_status_special_function #(
    parameter DATA_W = 8
) (
    // clock and reset
    input  wire                clock,
    input  wire                rst_n,
    // register port
    input  wire [`ADDR_W-1:0]  addr,
    input  wire [DATA_W-1:0]   wdata,
    input  wire                wr,
    input  wire                rd,
    output reg  [DATA_W-1:0]   rdata_q,
    // modem inputs
    input  wire                cts,
    input  wire                dsr,
    input  wire                ri,
    input  wire                dcd,
    // loopback controls from the modem control register
    input  wire                loopback_enable,
    input  wire                general_output_one,
    input  wire                general_output_two,
    // counters owned by the fifo and line logic
    input  wire [DATA_W-1:0]   rx_fill_count,
    input  wire [DATA_W-1:0]   line_error_count,
    input  wire [DATA_W-1:0]   tx_fill_count,
    // controls to the channel
    output reg                 force_tx_q,
    output reg                 auto_dsr_dtr_q,
    output reg                 compat_mode_q,
    output reg                 rx_count_or_error_count_select_q,
    output reg                 tx_count_or_sample_clock_select_q,
    output reg  [DATA_W-1:0]   sample_clock_q,
    // interrupt
    output reg                 irq_q
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire hit_status;
    wire hit_special;
    wire hit_tx_view;
    wire hit_int_status;
    wire hit_int_mask;

    assign hit_status     = (addr == `MODEM_STATUS_OFF);
    assign hit_special    = (addr == `SPECIAL_FN_OFF);
    assign hit_tx_view    = (addr == `TX_VIEW_OFF);
    assign hit_int_status = (addr == `INT_STATUS_OFF);
    assign hit_int_mask   = (addr == `INT_MASK_OFF);

    // ----------------------------------------------------------------
    // modem line selection
    // ----------------------------------------------------------------
    // in loopback the ring and carrier lines come from the general
    // outputs; the pins are ignored so the self test is not disturbed
    wire [`MODEM_LINES-1:0] lines;

    assign lines[`LINE_CTS] = cts;
    assign lines[`LINE_DSR] = dsr;
    assign lines[`LINE_RI]  = loopback_enable ? general_output_one : ri;   // see R14
    assign lines[`LINE_DCD] = loopback_enable ? general_output_two : dcd;  // see R14

    // ----------------------------------------------------------------
    // change detection
    // ----------------------------------------------------------------
    wire [`MODEM_LINES-1:0] level;
    wire [`MODEM_LINES-1:0] change_flag;
    wire [`MODEM_LINES-1:0] change_event;
    wire                    status_read;

    assign status_read = rd & hit_status;

    // cts, dsr and dcd flag both edges, ri only its rise
    modem_change_detect #(
        .WIDTH     (`MODEM_LINES),
        .RISE_ONLY (`RISE_ONLY_MASK)
    ) u_detect (
        .clock      (clock),
        .rst_n      (rst_n),
        .line_in    (lines),
        .flag_clear (status_read),
        .level_q    (level),
        .flag_q     (change_flag),
        .event_q    (change_event)
    );
    // see R1 see R2 see R3 see R4 see R16

    wire ring_rise_flag;
    wire carrier_change_flag;

    assign ring_rise_flag      = change_flag[`LINE_RI];   // see R3
    assign carrier_change_flag = change_flag[`LINE_DCD];  // see R4

    // flags low, levels high
    wire [DATA_W-1:0] status_word;

    assign status_word = {level[`LINE_DCD],                // see R8
                          level[`LINE_RI],                 // see R7
                          level[`LINE_DSR],                // see R6
                          level[`LINE_CTS],                // see R5
                          carrier_change_flag,
                          ring_rise_flag,
                          change_flag[`LINE_DSR],
                          change_flag[`LINE_CTS]};         // see R15

    // ----------------------------------------------------------------
    // special function register
    // ----------------------------------------------------------------
    // reserved bit 4 keeps what is written; bits 2 and 3 read zero
    reg spare_rw_q;

    wire special_write;

    assign special_write = wr & hit_special;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            force_tx_q                        <= 1'b0;
            auto_dsr_dtr_q                    <= 1'b0;
            spare_rw_q                        <= 1'b0;
            compat_mode_q                     <= 1'b0;
            rx_count_or_error_count_select_q  <= 1'b0;
            tx_count_or_sample_clock_select_q <= 1'b0;
        end else if (special_write) begin
            force_tx_q                        <= wdata[`FORCE_TX_BIT];      // see R9
            auto_dsr_dtr_q                    <= wdata[`AUTO_DSR_DTR_BIT];  // see R10
            spare_rw_q                        <= wdata[`SPARE_RW_BIT];
            compat_mode_q                     <= wdata[`COMPAT_MODE_BIT];   // see R11
            rx_count_or_error_count_select_q  <= wdata[`RX_VIEW_SEL_BIT];   // see R12
            tx_count_or_sample_clock_select_q <= wdata[`TX_VIEW_SEL_BIT];   // see R13
        end
    end

    wire [DATA_W-1:0] special_word;

    assign special_word = {tx_count_or_sample_clock_select_q,
                           rx_count_or_error_count_select_q,
                           compat_mode_q,
                           spare_rw_q,
                           1'b0,
                           1'b0,
                           auto_dsr_dtr_q,
                           force_tx_q};

    // ----------------------------------------------------------------
    // sample clock register
    // ----------------------------------------------------------------
    // only writable while its offset shows it; with the transmit count
    // selected the offset is read-only and writes are dropped
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sample_clock_q <= `SAMPLE_CLOCK_RESET;
        end else if (wr && hit_tx_view && !tx_count_or_sample_clock_select_q) begin
            sample_clock_q <= wdata;  // see R13
        end
    end

    // ----------------------------------------------------------------
    // shared counter offsets
    // ----------------------------------------------------------------
    wire [DATA_W-1:0] rx_view;
    wire [DATA_W-1:0] tx_view;

    counter_view_mux #(
        .DATA_W (DATA_W)
    ) u_view (
        .rx_count_or_error_count_select  (rx_count_or_error_count_select_q),   // see R12
        .tx_count_or_sample_clock_select (tx_count_or_sample_clock_select_q),  // see R13
        .rx_fill_count                   (rx_fill_count),
        .line_error_count                (line_error_count),
        .tx_fill_count                   (tx_fill_count),
        .sample_clock                    (sample_clock_q),
        .rx_view                         (rx_view),
        .tx_view                         (tx_view)
    );

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    // kept apart from the modem flags so software can poll the status
    // register without losing the interrupt cause, and vice versa
    reg  [`MODEM_LINES-1:0] int_status_q;
    reg  [`MODEM_LINES-1:0] int_mask_q;
    reg  [`MODEM_LINES-1:0] int_status_d;

    always @* begin
        int_status_d = int_status_q;
        if (rd && hit_int_status) begin
            int_status_d = {`MODEM_LINES{1'b0}};
        end
        // a new event beats the clearing read
        int_status_d = int_status_d | change_event;
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_status_q <= {`MODEM_LINES{1'b0}};
            int_mask_q   <= `INT_MASK_RESET;
            irq_q        <= 1'b0;
        end else begin
            int_status_q <= int_status_d;
            if (wr && hit_int_mask) begin
                int_mask_q <= wdata[`MODEM_LINES-1:0];
            end
            irq_q <= |(int_status_d & int_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    reg [DATA_W-1:0] read_mux;

    always @* begin
        case (addr)
            `MODEM_STATUS_OFF: read_mux = status_word;
            `SPECIAL_FN_OFF:   read_mux = special_word & `SPECIAL_FN_RW_MASK;
            `RX_VIEW_OFF:      read_mux = rx_view;
            `TX_VIEW_OFF:      read_mux = tx_view;
            `INT_STATUS_OFF:   read_mux = {{(DATA_W-`MODEM_LINES){1'b0}}, int_status_q};
            `INT_MASK_OFF:     read_mux = {{(DATA_W-`MODEM_LINES){1'b0}}, int_mask_q};
            default:           read_mux = `DATA_ZERO;
        endcase
    end

    // data stand for the one cycle after the read strobe, zero otherwise
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= `DATA_ZERO;
        end else if (rd) begin
            rdata_q <= read_mux;
        end else begin
            rdata_q <= `DATA_ZERO;
        end
    end

endmodule

`default_nettype wire

// ===== inc/uart_msr_sfr_consts.vh
// register offsets, field positions and reset values for the modem status / special function block
`ifndef UART_MSR_SFR_CONSTS_VH
`define UART_MSR_SFR_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_W               5
`define MODEM_STATUS_OFF     5'h06
`define SPECIAL_FN_OFF       5'h07
`define RX_VIEW_OFF          5'h15
`define TX_VIEW_OFF          5'h16
`define INT_STATUS_OFF       5'h18
`define INT_MASK_OFF         5'h19

// ----------------------------------------------------------------
// modem status fields
// ----------------------------------------------------------------
`define MODEM_LINES          4
`define FLAG_LSB             0
`define LEVEL_LSB            4
`define LINE_CTS             0
`define LINE_DSR             1
`define LINE_RI              2
`define LINE_DCD             3
// per-line edge policy: 1 = rising edge only
`define RISE_ONLY_MASK       4'h4

// ----------------------------------------------------------------
// special function fields
// ----------------------------------------------------------------
`define FORCE_TX_BIT         0
`define AUTO_DSR_DTR_BIT     1
`define SPARE_RW_BIT         4
`define COMPAT_MODE_BIT      5
`define RX_VIEW_SEL_BIT      6
`define TX_VIEW_SEL_BIT      7
// bits that store a written value; bits 2 and 3 read as zero
`define SPECIAL_FN_RW_MASK   8'hf3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPECIAL_FN_RESET     8'h00
`define SAMPLE_CLOCK_RESET   8'h00
`define INT_MASK_RESET       4'h0
`define DATA_ZERO            8'h00

`endif

// ===== src/modem_change_detect.v
// per-line level sampling and sticky change flags for the modem inputs
`timescale 1ns/1ps
`default_nettype none

module modem_change_detect #(
    parameter       WIDTH     = 4,
    parameter [3:0] RISE_ONLY = 4'h4
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // line side
    input  wire [WIDTH-1:0] line_in,
    // software side
    input  wire             flag_clear,
    // results
    output reg  [WIDTH-1:0] level_q,
    output reg  [WIDTH-1:0] flag_q,
    output reg  [WIDTH-1:0] event_q
);

    // the first sample after reset only seeds the levels, so a line
    // that is already high does not look like a change
    reg primed_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            primed_q <= 1'b0;
        end else begin
            primed_q <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_line
            wire rise;
            wire fall;
            wire hit;
            assign rise = primed_q & line_in[i] & ~level_q[i];
            assign fall = primed_q & ~line_in[i] & level_q[i];
            assign hit  = rise | (fall & ~RISE_ONLY[i]);

            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    level_q[i] <= 1'b0;
                    flag_q[i]  <= 1'b0;
                    event_q[i] <= 1'b0;
                end else begin
                    level_q[i] <= line_in[i];
                    event_q[i] <= hit;
                    // a change in the clearing cycle survives the read
                    if (hit) begin
                        flag_q[i] <= 1'b1;
                    end else if (flag_clear) begin
                        flag_q[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ===== src/counter_view_mux.v
// chooses what the two shared counter offsets return on a read
`timescale 1ns/1ps
`default_nettype none

module counter_view_mux #(
    parameter DATA_W = 8
) (
    // selects
    input  wire              rx_count_or_error_count_select,
    input  wire              tx_count_or_sample_clock_select,
    // sources
    input  wire [DATA_W-1:0] rx_fill_count,
    input  wire [DATA_W-1:0] line_error_count,
    input  wire [DATA_W-1:0] tx_fill_count,
    input  wire [DATA_W-1:0] sample_clock,
    // views
    output wire [DATA_W-1:0] rx_view,
    output wire [DATA_W-1:0] tx_view
);

    assign rx_view = rx_count_or_error_count_select ? line_error_count : rx_fill_count;
    assign tx_view = tx_count_or_sample_clock_select ? tx_fill_count : sample_clock;

endmodule

`default_nettype wire

// ===== tb/uart_msr_sfr_monitor.sv
// assertion checker for the modem status and special function registers
`timescale 1ns/1ps
`default_nettype none
`include "uart_msr_sfr_consts.vh"

module uart_msr_sfr_monitor #(
    parameter DATA_W = 8
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // register port
    input wire logic [4:0]        addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata_q,
    // modem lines and loopback
    input wire logic              cts,
    input wire logic              dsr,
    input wire logic              ri,
    input wire logic              dcd,
    input wire logic              loopback_enable,
    input wire logic              general_output_one,
    input wire logic              general_output_two,
    // counters and controls
    input wire logic [DATA_W-1:0] rx_fill_count,
    input wire logic [DATA_W-1:0] line_error_count,
    input wire logic [DATA_W-1:0] tx_fill_count,
    input wire logic              force_tx_q,
    input wire logic              auto_dsr_dtr_q,
    input wire logic              compat_mode_q,
    input wire logic              rx_count_or_error_count_select_q,
    input wire logic              tx_count_or_sample_clock_select_q,
    input wire logic [DATA_W-1:0] sample_clock_q
);
    // ------------------------------------------------------------
    // reference sampling of the lines as the block sees them
    // ------------------------------------------------------------
    wire [3:0] v = {loopback_enable ? general_output_two : dcd, loopback_enable ? general_output_one : ri, dsr, cts};
    logic [3:0] v_q, hit_q;
    logic       seed_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {v_q, hit_q, seed_q} <= 9'h000;
        end else begin
            v_q <= v;
            seed_q <= 1'b1;
            hit_q <= seed_q ? (((v ^ v_q) & 4'hb) | (v & ~v_q & 4'h4)) : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_levels; rd && addr == `MODEM_STATUS_OFF |=> rdata_q[7:4] == $past(v_q); endproperty
    a_levels: assert property (p_levels) else $error("level bits wrong");
    property p_flag_keep; rd && addr == `MODEM_STATUS_OFF |=> (rdata_q[3:0] & $past(hit_q)) == $past(hit_q); endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("change flag lost");
    property p_flag_clear; rd && addr == `MODEM_STATUS_OFF ##1 rd && addr == `MODEM_STATUS_OFF |=> rdata_q[3:0] == $past(hit_q); endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");
    property p_sfr_back; wr && addr == `SPECIAL_FN_OFF ##1 rd && addr == `SPECIAL_FN_OFF |=> rdata_q == ($past(wdata, 2) & `SPECIAL_FN_RW_MASK); endproperty
    a_sfr_back: assert property (p_sfr_back) else $error("special register readback wrong");
    property p_force; wr && addr == `SPECIAL_FN_OFF |=> force_tx_q == $past(wdata[0]); endproperty
    a_force: assert property (p_force) else $error("force transmit wrong");
    property p_modes; wr && addr == `SPECIAL_FN_OFF |=> {tx_count_or_sample_clock_select_q, rx_count_or_error_count_select_q, compat_mode_q, auto_dsr_dtr_q} == {$past(wdata[7:5]), $past(wdata[1])}; endproperty
    a_modes: assert property (p_modes) else $error("mode bits wrong");
    property p_rx_view; rd && addr == `RX_VIEW_OFF |=> rdata_q == ($past(rx_count_or_error_count_select_q) ? $past(line_error_count) : $past(rx_fill_count)); endproperty
    a_rx_view: assert property (p_rx_view) else $error("rx view wrong");
    property p_tx_view; rd && addr == `TX_VIEW_OFF |=> rdata_q == ($past(tx_count_or_sample_clock_select_q) ? $past(tx_fill_count) : $past(sample_clock_q)); endproperty
    a_tx_view: assert property (p_tx_view) else $error("tx view wrong");
endmodule

bind uart_modem_status_special_function uart_msr_sfr_monitor #(.DATA_W(DATA_W)) uart_msr_sfr_monitor_i (.*);
`default_nettype wire

// ===== tb/modem_line_model.sv
// behavioural modem driving the four modem status lines
`timescale 1ns/1ps
`default_nettype none

module modem_line_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // requests from the bench
    input  wire logic       load,
    input  wire logic [3:0] pattern,
    input  wire logic [1:0] lag,
    // modem lines
    output var logic        cts,
    output var logic        dsr,
    output var logic        ri,
    output var logic        dcd
);
    // a new pattern lands at once or lag cycles later, like a slow modem
    logic [3:0] pend_q;
    logic [1:0] wait_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {pend_q, wait_q, dcd, ri, dsr, cts} <= 10'h000;
        end else if (load) begin
            pend_q <= pattern;
            wait_q <= lag;
            if (lag == 2'h0) begin
                {dcd, ri, dsr, cts} <= pattern;
            end
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
            if (wait_q == 2'h1) begin
                {dcd, ri, dsr, cts} <= pend_q;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_uart_modem_status_special_function.sv
// self-checking bench for the modem status and special function registers
`timescale 1ns/1ps
`default_nettype none
`include "uart_msr_sfr_consts.vh"

module test_uart_modem_status_special_function;
    logic       clock, rst_n, wr, rd, load, irq_q, cts, dsr, ri, dcd, seeded;
    logic       loopback_enable, general_output_one, general_output_two;
    logic       force_tx_q, auto_dsr_dtr_q, compat_mode_q;
    logic       rx_count_or_error_count_select_q, tx_count_or_sample_clock_select_q;
    logic [4:0] addr;
    logic [7:0] wdata, rdata_q, sample_clock_q, rx_fill_count, line_error_count, tx_fill_count, sf, sc, ex;
    logic [3:0] pattern, v, lv, fl, ist, pend, hit, msk;
    logic [1:0] lag;
    logic [31:0] r;
    logic [4:0] amap [0:7] = '{5'h06, 5'h07, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1f, 5'h03};
    integer     seed = 36160;
    int         num_errors = 0, n_tests = 0, i;

    uart_modem_status_special_function uart_modem_status_special_function_i (.*);
    modem_line_model modem_line_model_i (.*);

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // expectation model and checks
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_rd(input logic [4:0] a);
        case (a)
            `MODEM_STATUS_OFF: return {lv, fl};
            `SPECIAL_FN_OFF:   return sf;
            `RX_VIEW_OFF:      return sf[6] ? line_error_count : rx_fill_count;
            `TX_VIEW_OFF:      return sf[7] ? tx_fill_count : sc;
            `INT_STATUS_OFF:   return {4'h0, ist};
            `INT_MASK_OFF:     return {4'h0, msk};
            default:           return 8'h00;
        endcase
    endfunction

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {lv, fl, ist, pend, msk, sf, sc, ex, seeded} = '0;
        end else begin
            v = {loopback_enable ? general_output_two : dcd, loopback_enable ? general_output_one : ri, dsr, cts};
            hit = seeded ? (((v ^ lv) & 4'hb) | (v & ~lv & 4'h4)) : 4'h0;
            ex = rd ? exp_rd(addr) : 8'h00;
            if (rd && addr == `MODEM_STATUS_OFF) fl = 4'h0;
            if (rd && addr == `INT_STATUS_OFF) ist = 4'h0;
            ist = ist | pend;
            pend = hit;
            fl = fl | hit;
            lv = v;
            seeded = 1'b1;
            if (wr && addr == `SPECIAL_FN_OFF) sf = wdata & `SPECIAL_FN_RW_MASK;
            if (wr && addr == `TX_VIEW_OFF && !sf[7]) sc = wdata;
            if (wr && addr == `INT_MASK_OFF) msk = wdata[3:0];
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(negedge clock) begin
        if (rst_n) begin
            check(rdata_q, ex);
            check({3'h0, tx_count_or_sample_clock_select_q, rx_count_or_error_count_select_q, compat_mode_q, auto_dsr_dtr_q, force_tx_q}, {3'h0, sf[7:5], sf[1:0]});
            check(sample_clock_q, sc);
        end
    end

    task automatic give_verdict;
        $display("%0d checks, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus and line tasks
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
    endtask

    task automatic lines(input logic [3:0] p, input logic [1:0] l);
        @(posedge clock);
        pattern <= p;
        lag <= l;
        load <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {wr, rd, load, addr, wdata, pattern, lag, loopback_enable, general_output_one, general_output_two} = '0;
        {rx_fill_count, line_error_count, tx_fill_count} = '0;
        rst_n = 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 32; i++) rd_reg(i[4:0]);
        for (i = 0; i < 32; i++) wr_reg(i[4:0], 8'hff);
        for (i = 0; i < 32; i++) rd_reg(i[4:0]);
        $display("reset and register map test done");
        // write then read the special register with no gap between strobes
        @(posedge clock);
        addr <= `SPECIAL_FN_OFF;
        wdata <= 8'h5e;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        $display("back to back test done");
        // change detected on the very edge that takes the clearing read
        @(posedge clock);
        pattern <= 4'h1;
        lag <= 2'd0;
        load <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        addr <= `MODEM_STATUS_OFF;
        rd <= 1'b1;
        repeat (2) @(posedge clock);
        rd <= 1'b0;
        rd_reg(`MODEM_STATUS_OFF);
        $display("read collision test done");
        wr_reg(`INT_MASK_OFF, 8'h01);
        rd_reg(`INT_STATUS_OFF);
        lines(4'h3, 2'd2);
        repeat (6) @(negedge clock);
        check({7'h0, irq_q}, 8'h00);
        lines(4'h2, 2'd1);
        repeat (6) @(negedge clock);
        check({7'h0, irq_q}, 8'h01);
        rd_reg(`INT_STATUS_OFF);
        repeat (3) @(negedge clock);
        check({7'h0, irq_q}, 8'h00);
        @(posedge clock);
        $display("interrupt test done");
        for (i = 0; i < 600; i++) begin
            r = $random(seed);
            rx_fill_count <= r[7:0];
            line_error_count <= r[15:8];
            tx_fill_count <= r[23:16];
            {loopback_enable, general_output_one, general_output_two} <= r[26:24];
            case (r[28:27])
                2'd0: lines(r[3:0], r[30:29]);
                2'd1: wr_reg(amap[r[6:4]], r[31:24]);
                default: rd_reg(amap[r[6:4]]);
            endcase
        end
        $display("random traffic test done");
        give_verdict();
    end

    // about 1430 cycles are expected; this allows ample margin
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
